// ==== src/lowvolt_gpio_pair.sv ====
/*
  Control logic for two low-voltage general-purpose pins: control
  registers 35 and 36, input synchronising and debounce, edge events
  and registered pad drive and configuration.
  Assumes the serial control interface delivers one-cycle read and write
  strobes on mclk, and that pad_in is asynchronous to mclk.
*/
`timescale 1ns/1ps
`include "lvgpio_defs.svh"
`default_nettype none

module lowvolt_gpio_pair #(
  parameter int unsigned DBNC_UNIT_CYC = `DBNC_STEP_MS * `MCLK_KHZ
) (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [5:0]             reg_addr,
  input  wire logic [23:0]            reg_wdata,
  output logic      [23:0]            reg_rdata,
  output logic                        reg_rvalid,
  input  wire logic [1:0]             pad_in,
  output logic      [1:0]             pad_out,
  output logic      [1:0]             pad_oe_n,
  output lvgpio_pkg::pad_cfg_t [1:0]  pad_cfg,
  output logic      [1:0]             pin_event,
  input  wire logic [1:0]             event_clr
);
  import lvgpio_pkg::*;

  localparam int CW = $clog2(3 * DBNC_UNIT_CYC + 1);

  // ************************************************
  // Helpers
  // ************************************************
  function automatic logic [CW-1:0] dbnc_limit(input dbnc_t sel);
    logic [CW-1:0] unit;
    unit = CW'(DBNC_UNIT_CYC);
    unique case (sel)
      DBNC_OFF:  dbnc_limit = '0;
      DBNC_10MS: dbnc_limit = unit;
      DBNC_20MS: dbnc_limit = CW'(2 * DBNC_UNIT_CYC);
      DBNC_30MS: dbnc_limit = CW'(3 * DBNC_UNIT_CYC);
    endcase
  endfunction

  function automatic logic edge_match(input edge_mode_t m,
                                      input logic rise,
                                      input logic fall);
    unique case (m)
      EDGE_NONE: edge_match = 1'b0;
      EDGE_FALL: edge_match = fall;
      EDGE_RISE: edge_match = rise;
      EDGE_BOTH: edge_match = rise | fall;
    endcase
  endfunction

  function automatic logic [5:0] pin_addr(input int i);
    pin_addr = (i == 0) ? `LV_REG_PIN_TWO : `LV_REG_PIN_THREE;
  endfunction

  // ************************************************
  // State
  // ************************************************
  ctrl_t [1:0]          ctrl_q,   ctrl_d;
  logic  [1:0]          sync1_q,  sync1_d;
  logic  [1:0]          sync2_q,  sync2_d;
  logic  [1:0]          filt_q,   filt_d;
  logic  [1:0][CW-1:0]  cnt_q,    cnt_d;
  logic  [1:0]          event_q,  event_d;
  logic  [1:0]          out_q,    out_d;
  logic  [1:0]          oe_n_q,   oe_n_d;
  pad_cfg_t [1:0]       cfg_q,    cfg_d;
  logic  [23:0]         rdata_q,  rdata_d;
  logic                 rvalid_q, rvalid_d;
  logic  [1:0]          hit;

  // ************************************************
  // Control registers
  // ************************************************
  always_comb begin
    ctrl_d = ctrl_q;
    for (int i = 0; i < 2; i++) begin
      if (reg_wr && reg_addr == pin_addr(i)) begin
        // Upper byte and the read-only level bit are dropped here
        ctrl_d[i] = ctrl_t'(reg_wdata[15:0] & `LV_CTRL_WMASK);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= {2{ctrl_t'(`LV_CTRL_RST)}};
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ************************************************
  // Register read
  // ************************************************
  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = reg_rd;
    if (reg_rd) begin
      rdata_d = 24'h000000;
      for (int i = 0; i < 2; i++) begin
        if (reg_addr == pin_addr(i)) begin
          rdata_d[15:0]        = ctrl_q[i];
          rdata_d[`LV_DIN_BIT] = filt_q[i];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q  <= 24'h000000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ************************************************
  // Input path: synchroniser, debounce, edge events
  // ************************************************
  always_comb begin
    sync1_d = pad_in;
    sync2_d = sync1_q;
    filt_d  = filt_q;
    cnt_d   = cnt_q;
    for (int i = 0; i < 2; i++) begin
      // Level must differ for the whole window before it is taken
      if (sync2_q[i] == filt_q[i]) begin
        cnt_d[i] = '0;
      end else if (cnt_q[i] + 1'b1 >=
                   dbnc_limit(ctrl_q[i].glitch_filter_time)) begin
        filt_d[i] = sync2_q[i];
        cnt_d[i]  = '0;
      end else begin
        cnt_d[i] = cnt_q[i] + 1'b1;
      end
      hit[i] = edge_match(ctrl_q[i].irq_edge,
                          ~filt_q[i] & filt_d[i],
                          filt_q[i] & ~filt_d[i]);
    end
    // A new edge beats a clear in the same cycle
    event_d = (event_q & ~event_clr) | hit;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1_q <= 2'b00;
      sync2_q <= 2'b00;
      filt_q  <= 2'b00;
      cnt_q   <= '0;
      event_q <= 2'b00;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      filt_q  <= filt_d;
      cnt_q   <= cnt_d;
      event_q <= event_d;
    end
  end

  // ************************************************
  // Pad drive and configuration
  // ************************************************
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      out_d[i] = ctrl_q[i].out_level;
      // Open drain only pulls low; a high level releases the pad
      oe_n_d[i] = ~(ctrl_q[i].dir_out &
                    ~(ctrl_q[i].opendrain_select &
                      ctrl_q[i].out_level));
      cfg_d[i].edge_rate_select     = ctrl_q[i].edge_rate_select;
      cfg_d[i].pull_kind_select     = ctrl_q[i].pull_kind_select;
      cfg_d[i].pull_resistor_on     = ctrl_q[i].pull_resistor_on;
      cfg_d[i].drive_current_select = ctrl_q[i].drive_current_select;
      cfg_d[i].pad_keeper_on        = ctrl_q[i].pad_keeper_on;
      cfg_d[i].schmitt_select       = ctrl_q[i].schmitt_select;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      out_q  <= 2'b00;
      oe_n_q <= 2'b11;
      cfg_q  <= {2{pad_cfg_t'(`LV_PADCFG_RST)}};
    end else begin
      out_q  <= out_d;
      oe_n_q <= oe_n_d;
      cfg_q  <= cfg_d;
    end
  end

  assign pad_out    = out_q;
  assign pad_oe_n   = oe_n_q;
  assign pad_cfg    = cfg_q;
  assign pin_event  = event_q;
  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_DIR_INPUT_RELEASES: assert property (
    !ctrl_q[0].dir_out |=> pad_oe_n[0])
    else $error("pin two driven while set as input");

  AST_DIN_READBACK: assert property (
    reg_rd && reg_addr == `LV_REG_PIN_THREE
    |=> reg_rvalid && reg_rdata[`LV_DIN_BIT] == $past(filt_q[1]))
    else $error("read level does not match filtered input");

  AST_DOUT_DRIVE: assert property (
    ctrl_q[1].dir_out && !ctrl_q[1].opendrain_select
    |=> !pad_oe_n[1] && pad_out[1] == $past(ctrl_q[1].out_level))
    else $error("push-pull output level wrong");

  AST_OPEN_DRAIN_HIGH: assert property (
    ctrl_q[0].dir_out && ctrl_q[0].opendrain_select &&
    ctrl_q[0].out_level |=> pad_oe_n[0])
    else $error("open drain drove a high level");

  AST_NO_DEBOUNCE_FAST: assert property (
    ctrl_q[0].glitch_filter_time == DBNC_OFF &&
    sync2_q[0] != filt_q[0] |=> filt_q[0] == $past(sync2_q[0]))
    else $error("undebounced input lagged");

  AST_DEBOUNCE_HOLDS: assert property (
    ctrl_q[1].glitch_filter_time == DBNC_10MS &&
    cnt_q[1] == '0 && sync2_q[1] != filt_q[1]
    |=> filt_q[1] == $past(filt_q[1]))
    else $error("debounce passed a one-cycle change");

  AST_RISE_EVENT: assert property (
    $past(ctrl_q[1].irq_edge) == EDGE_RISE && $rose(filt_q[1])
    |-> pin_event[1])
    else $error("rising edge missed");

  AST_NO_EDGE_NO_EVENT: assert property (
    ctrl_q[0].irq_edge == EDGE_NONE && !event_q[0] |=> !pin_event[0])
    else $error("event raised with edges off");

  AST_UPPER_ZERO: assert property (
    reg_rvalid |-> reg_rdata[23:16] == 8'h00)
    else $error("unused bits read nonzero");

  AST_WRITE_TAKES: assert property (
    reg_wr && reg_addr == `LV_REG_PIN_TWO
    |=> ctrl_q[0][15:2] == $past(reg_wdata[15:2]))
    else $error("write to pin two register lost");

  AST_PAD_CFG_FOLLOWS: assert property (
    ##1 pad_cfg[1].pull_kind_select == $past(ctrl_q[1].pull_kind_select))
    else $error("pull select not applied to pin three");

  AST_FALL_EVENT: assert property (
    $past(ctrl_q[0].irq_edge) == EDGE_FALL && $fell(filt_q[0])
    |-> pin_event[0])
    else $error("falling edge missed");

  AST_SET_BEATS_CLEAR: assert property (
    hit[0] |=> pin_event[0])
    else $error("matching edge did not set the event flag");

  AST_CLEAR_DROPS: assert property (
    event_clr[1] && !hit[1] |=> !pin_event[1])
    else $error("event flag survived a clear");

  AST_KEEPER_FOLLOWS: assert property (
    ##1 pad_cfg[0].pad_keeper_on == $past(ctrl_q[0].pad_keeper_on))
    else $error("keeper setting not applied to pin two");

  AST_UNMAPPED_READ_ZERO: assert property (
    reg_rd && reg_addr != `LV_REG_PIN_TWO &&
    reg_addr != `LV_REG_PIN_THREE
    |=> reg_rdata == 24'h000000)
    else $error("unmapped register read nonzero");

  // Own disable so the reset values themselves get checked
  AST_RESET_DEFAULTS: assert property (
    disable iff (1'b0)
    rst |=> ctrl_q[1] == ctrl_t'(`LV_CTRL_RST) && pad_oe_n == 2'b11 &&
            pad_cfg[0] == pad_cfg_t'(`LV_PADCFG_RST) && pin_event == 2'b00)
    else $error("reset left a field off its default");

  COV_WRITE_THREE: cover property (
    reg_wr && reg_addr == `LV_REG_PIN_THREE);
  COV_FALL_EVENT: cover property (
    ctrl_q[0].irq_edge == EDGE_FALL && $rose(pin_event[0]));
  COV_DEBOUNCED_FLIP: cover property (
    ctrl_q[1].glitch_filter_time != DBNC_OFF && $changed(filt_q[1]));
  COV_OPEN_DRAIN_LOW: cover property (
    ctrl_q[0].opendrain_select && !pad_oe_n[0] && !pad_out[0]);
  COV_UNMAPPED_READ: cover property (
    reg_rd && reg_addr == 6'h25);

endmodule
`default_nettype wire

// ==== src/lvgpio_defs.svh ====
/*
  Constants for the low-voltage pin pair: register numbers, field
  positions, reset values and debounce timing.
  Assumes mclk runs at 50 MHz and register numbers are six bits wide.
*/
// Functional notes
// - Bit 0 sets direction, 0 input, 1 output; resets to 0.
// - Bit 1 reads back the sampled, debounced pin level.
// - Bit 2 is the level driven when output; resets to 0.
// - Bit 3 picks CMOS (0) or hysteresis (1) input; resets to 1.
// - Bits 5-4 pick debounce: off, 10 ms, 20 ms or 30 ms.
// - Bits 7-6 pick interrupt edges: none, falling, rising, both; reset 0.
// - Bit 8 turns the pad keeper on; resets to 0.
// - Bit 9 picks push-pull (0) or open-drain (1) output; resets to 0.
// - Bit 11 enables the pull resistor; resets to 1.
// - Bits 13-12 pick 10K/100K pull-down or pull-up; resets to 11.
// - Bits 15-14 pick slew rate, slow to very fast; resets slow.
// - First pin's control register sits at register number 35.
// - Second pin has its own register 36, same layout and defaults.
`ifndef LVGPIO_DEFS_SVH
`define LVGPIO_DEFS_SVH

`define LV_REG_PIN_TWO   6'h23
`define LV_REG_PIN_THREE 6'h24

`define LV_DIR_BIT       0
`define LV_DIN_BIT       1
`define LV_DOUT_BIT      2

`define LV_CTRL_RST      16'h3808
`define LV_CTRL_WMASK    16'hFFFD
`define LV_PADCFG_RST    8'h39

`define DBNC_STEP_MS     10
`define MCLK_KHZ         50000

`endif

// ==== src/lvgpio_pkg.sv ====
/*
  Types for the low-voltage pin pair: control word layout, pad
  configuration bundle and field encodings.
  Assumes lvgpio_defs.svh is available to the design file.
*/
package lvgpio_pkg;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_RISE = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_mode_t;

  typedef enum logic [1:0] {
    DBNC_OFF  = 2'b00,
    DBNC_10MS = 2'b01,
    DBNC_20MS = 2'b10,
    DBNC_30MS = 2'b11
  } dbnc_t;

  typedef struct packed {
    logic [1:0] edge_rate_select;
    logic [1:0] pull_kind_select;
    logic       pull_resistor_on;
    logic       drive_current_select;
    logic       opendrain_select;
    logic       pad_keeper_on;
    edge_mode_t irq_edge;
    dbnc_t      glitch_filter_time;
    logic       schmitt_select;
    logic       out_level;
    logic       in_level;
    logic       dir_out;
  } ctrl_t;

  typedef struct packed {
    logic [1:0] edge_rate_select;
    logic [1:0] pull_kind_select;
    logic       pull_resistor_on;
    logic       drive_current_select;
    logic       pad_keeper_on;
    logic       schmitt_select;
  } pad_cfg_t;

endpackage

// ==== tb/low_voltage_gpio_pair_control_tb_top.sv ====
/*
  Self-checking bench for lowvolt_gpio_pair with a pin load model.
  Assumes a shortened debounce unit of 8 cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module low_voltage_gpio_pair_control_tb_top;
  import lvgpio_pkg::*;
  localparam int U = 8;
  logic           mclk, rst, reg_wr, reg_rd, reg_rvalid;
  logic [5:0]     reg_addr;
  logic [23:0]    reg_wdata, reg_rdata, rd_q, w;
  logic [1:0]     pad_in, pad_out, pad_oe_n, pin_event, event_clr;
  logic [1:0]     ext_en, ext_lvl;
  pad_cfg_t [1:0] pad_cfg;
  logic [23:0]    sh [2];
  logic [31:0]    seed = 32'h000094F2;
  logic [31:0]    r;
  int             err_count, num_checks, p, L;

  lowvolt_gpio_pair #(.DBNC_UNIT_CYC(U)) dut (.mclk, .rst, .reg_wr,
    .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .pad_in,
    .pad_out, .pad_oe_n, .pad_cfg, .pin_event, .event_clr);
  lvgpio_pin_load ld (.mclk, .pad_out, .pad_oe_n, .pad_cfg, .ext_en,
    .ext_lvl, .pad_in);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic drv(input logic [23:0] v);
    return v[0] && !(v[9] && v[2]);
  endfunction

  function automatic logic [23:0] exp_rd(input int q);
    logic l;
    l = drv(sh[q]) ? sh[q][2] : (ext_en[q] ? ext_lvl[q] : sh[q][13]);
    return {8'h00, sh[q][15:0] & 16'hFFFD} | {22'h000000, l, 1'b0};
  endfunction

  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pad(input logic [7:0] got, input logic [7:0] exp);
    chk_word({16'h0000, got}, {16'h0000, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    cyc(1);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    cyc(1);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [5:0] a);
    cyc(1);
    reg_rd = 1'b1;
    reg_addr = a;
    cyc(1);
    reg_rd = 1'b0;
    chk_pad({7'h00, reg_rvalid}, 8'h01);
    rd_q = reg_rdata;
  endtask

  task automatic clr();
    event_clr = 2'h3;
    cyc(1);
    event_clr = 2'h0;
  endtask

  task automatic chk_def();
    cyc(8);
    for (int q = 0; q < 2; q++) begin
      rd(6'h23 + 6'(q));
      chk_word(rd_q, 24'h00380A);
      chk_pad(pad_cfg[q], 8'h39);
      chk_pad({5'h00, pin_event[q], pad_oe_n[q], pad_out[q]}, 8'h02);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Whole run is under a thousand cycles; limit leaves wide margin
  initial begin
    #400000;
    err_count++;
    test_done();
  end

  initial begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'h4, 30'h00000000};
    {event_clr, ext_en, ext_lvl} = 6'h00;
    repeat (5) @(posedge mclk);
    #1;
    rst = 1'b0;
    chk_def();
    $display("Test reset done");
    sh[0] = 24'h003808;
    sh[1] = 24'h003808;
    repeat (12) begin
      r = xs();
      p = int'(r[31]);
      w = 24'(xs());
      ext_en[p] = r[0];
      ext_lvl[p] = r[1];
      w[11] = w[11] | !r[0];
      wr(6'h23 + 6'(p), w);
      sh[p] = {8'h00, w[15:0]};
      cyc(1);
      chk_pad({7'h00, pad_out[p]}, {7'h00, w[2]});
      chk_pad({7'h00, pad_oe_n[p]}, {7'h00, !drv(w)});
      chk_pad(pad_cfg[p], {w[15:10], w[8], w[3]});
      cyc(40);
      for (int q = 0; q < 2; q++) begin
        rd(6'h23 + 6'(q));
        chk_word(rd_q, exp_rd(q));
      end
    end
    wr(6'h25, 24'hFFFFFF);
    rd(6'h25);
    chk_word(rd_q, 24'h000000);
    rd(6'h23);
    chk_word(rd_q, exp_rd(0));
    $display("Test register done");
    ext_en = 2'h3;
    ext_lvl = 2'h0;
    for (int m = 0; m < 4; m++) begin
      sh[0] = 24'h003808 | (24'(m) << 6);
      wr(6'h23, sh[0]);
      cyc(10);
      clr();
      ext_lvl[0] = 1'b1;
      cyc(6);
      chk_pad({7'h00, pin_event[0]}, {7'h00, m[1]});
      clr();
      ext_lvl[0] = 1'b0;
      cyc(6);
      chk_pad({7'h00, pin_event[0]}, {7'h00, m[0]});
    end
    $display("Test edge done");
    for (int k = 1; k < 4; k++) begin
      L = U * k;
      ext_lvl[1] = 1'b0;
      wr(6'h24, 24'h0038C8 | (24'(k) << 4));
      cyc(L + 10);
      clr();
      ext_lvl[1] = 1'b1;
      cyc(L - 2);
      ext_lvl[1] = 1'b0;
      cyc(L + 6);
      chk_pad({7'h00, pin_event[1]}, 8'h00);
      ext_lvl[1] = 1'b1;
      cyc(L);
      chk_pad({7'h00, pin_event[1]}, 8'h00);
      cyc(6);
      chk_pad({7'h00, pin_event[1]}, 8'h01);
    end
    $display("Test debounce done");
    ext_en = 2'h0;
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    chk_def();
    $display("Test second reset done");
    test_done();
  end
endmodule

`default_nettype wire

// ==== tb/lvgpio_pin_load.sv ====
/*
  Model of the circuits on the two low-voltage pins: external driver,
  pull resistor and floating node.
  Assumes the pad outputs of lowvolt_gpio_pair and bench-driven ext lines.
*/
`timescale 1ns/1ps
`default_nettype none

module lvgpio_pin_load
  import lvgpio_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic [1:0]     pad_out,
  input  wire logic [1:0]     pad_oe_n,
  input  wire pad_cfg_t [1:0] pad_cfg,
  input  wire logic [1:0]     ext_en,
  input  wire logic [1:0]     ext_lvl,
  output logic      [1:0]     pad_in
);
  logic [1:0] flt_q;

  // Floating node toggles so a stale level never looks valid
  always @(posedge mclk) begin
    flt_q <= ~pad_in;
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (!pad_oe_n[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_lvl[i];
      end else if (pad_cfg[i].pull_resistor_on) begin
        pad_in[i] = pad_cfg[i].pull_kind_select[1];
      end else begin
        pad_in[i] = flt_q[i];
      end
    end
  end
endmodule

`default_nettype wire
